// File: watchdog_consts.svh
// Constants for the operating watchdog: map, field positions, timing.
// Assumes a 40 MHz system clock and an 88 kHz internal oscillator rate.
`ifndef WATCHDOG_CONSTS_SVH
`define WATCHDOG_CONSTS_SVH

`define WDT_ADDR_W 18
`define WDT_CONFIG_ADDR 18'h00000
`define WDT_STATUS_ADDR 18'h00004
`define WDT_SERVICE_INDEX 18'h0ffff
`define WDT_SERVICE_ADDR (18'(`WDT_SERVICE_INDEX << 2))

`define WDT_CFG_RATE_BIT 0
`define WDT_CFG_DIS_BIT 1
`define WDT_CFG_STOPDIS_BIT 2
`define WDT_ST_CAUSE_BIT 0
`define WDT_ST_RUN_BIT 1
`define WDT_ST_MON_BIT 2
`define WDT_ST_CNT_LSB 8

`define WDT_PRE_W 12
`define WDT_CNT_W 6
`define WDT_PERIOD_SHORT (18'((1 << 13) - (1 << 4)))
`define WDT_PERIOD_LONG (18'((1 << 18) - (1 << 4)))
`define WDT_PULSE_TICKS 32
`define WDT_POR_TICKS 4096

`define WDT_CLK_HZ 40000000
`define WDT_OSC_HZ 88000
`define WDT_OSC_DIV ((`WDT_CLK_HZ) / (`WDT_OSC_HZ))

`define WDT_RESP_OKAY 2'h0
`define WDT_RESP_SLVERR 2'h2

`endif

// File: watchdog_pkg.sv
// Types shared by the watchdog modules.
// Assumes watchdog_consts.svh supplies all numbers.
package watchdog_pkg;

	typedef struct packed {
		logic stop_disable;
		logic watchdog_disable;
		logic timeout_rate_select;
	} cfg_type;

	typedef struct packed {
		logic irq_pin;
		logic rst_pin;
	} test_high_voltage_type;

	typedef enum logic [1:0] {
		MON_OFF,
		MON_TEST_V,
		MON_BLANK
	} mon_state_type;

endpackage

// File: sync2.sv
// Two-stage synchroniser for asynchronous level inputs.
// Assumes inputs are levels that stay stable for several clocks.
`timescale 1ns/100ps
module sync2 #(
	parameter int WIDTH = 1
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_r;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			meta_r <= '0;
			sync_o <= '0;
		end else begin
			meta_r <= async_i;
			sync_o <= meta_r;
		end
	end
endmodule

// File: operating_watchdog_timer.sv
// Watchdog timer with AXI4-Lite registers and reset pin drive.
// Assumes CPU event inputs are on CLK_I; test voltage senses are async.
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/100ps
`include "watchdog_consts.svh"
module operating_watchdog_timer
	import watchdog_pkg::*;
#(
	parameter int OSC_DIV = `WDT_OSC_DIV,
	parameter logic [7:0] RESET_VECTOR_LOW = 8'h00 // Arbitrary value
) (
	input wire logic CLK_I,
	input wire logic RESET_I,
	input wire logic [`WDT_ADDR_W-1:0] S_AXI_AWADDR_I,
	input wire logic S_AXI_AWVALID_I,
	output logic S_AXI_AWREADY_O,
	input wire logic [31:0] S_AXI_WDATA_I,
	input wire logic [3:0] S_AXI_WSTRB_I,
	input wire logic S_AXI_WVALID_I,
	output logic S_AXI_WREADY_O,
	output logic [1:0] S_AXI_BRESP_O,
	output logic S_AXI_BVALID_O,
	input wire logic S_AXI_BREADY_I,
	input wire logic [`WDT_ADDR_W-1:0] S_AXI_ARADDR_I,
	input wire logic S_AXI_ARVALID_I,
	output logic S_AXI_ARREADY_O,
	output logic [31:0] S_AXI_RDATA_O,
	output logic [1:0] S_AXI_RRESP_O,
	output logic S_AXI_RVALID_O,
	input wire logic S_AXI_RREADY_I,
	input wire logic INT_RESET_I,
	input wire logic STOP_EXEC_I,
	input wire logic STOP_MODE_I,
	input wire logic VECTOR_FETCH_I,
	input wire logic MON_ENTER_I,
	input wire logic BREAK_I,
	input wire logic IRQ_TEST_V_I,
	input wire logic RST_TEST_V_I,
	output logic RST_PIN_O,
	output logic RST_PIN_OE_O,
	output logic SYS_RESET_O,
	output logic ILLEGAL_RESET_O
);
	localparam int DIV_W = $clog2(OSC_DIV + 1);
	localparam int TOT_W = `WDT_PRE_W + `WDT_CNT_W;

	if (OSC_DIV < 2) begin : g_bad_div
		$error("OSC_DIV must be at least 2");
	end

	// Bus state
	logic aw_held_r;
	logic w_held_r;
	logic [`WDT_ADDR_W-1:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic commit;
	logic wr_config;
	logic wr_status;
	logic wr_service;
	logic ar_take;
	logic [31:0] rdata_nxt;
	logic [1:0] rresp_nxt;

	// Watchdog state
	cfg_type cfg_r;
	logic cause_r;
	mon_state_type mon_r;
	test_high_voltage_type tv;
	logic [DIV_W-1:0] div_r;
	logic tick;
	logic [`WDT_PRE_W-1:0] pre_r;
	logic [`WDT_CNT_W-1:0] cnt_r;
	logic [TOT_W-1:0] elapsed;
	logic [TOT_W-1:0] period;
	logic [12:0] por_cnt_r;
	logic por_done_r;
	logic por_clr;
	logic [5:0] pulse_r;
	logic overflow;
	logic disabled;
	logic clear_all;
	logic clear_pre;
	logic stop_gate;

	sync2 #(
		.WIDTH(2)
	) u_tv_sync (
		.clk_i(CLK_I),
		.reset_i(RESET_I),
		.async_i({IRQ_TEST_V_I, RST_TEST_V_I}),
		.sync_o(tv)
	);

	// Write address and data are taken independently, then committed
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			S_AXI_AWREADY_O <= 1'b0;
			aw_held_r <= 1'b0;
			awaddr_r <= '0;
		end else if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
			S_AXI_AWREADY_O <= 1'b0;
			aw_held_r <= 1'b1;
			awaddr_r <= S_AXI_AWADDR_I;
		end else begin
			if (commit) begin
				aw_held_r <= 1'b0;
			end
			S_AXI_AWREADY_O <= !aw_held_r && !S_AXI_BVALID_O;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			S_AXI_WREADY_O <= 1'b0;
			w_held_r <= 1'b0;
			wdata_r <= '0;
			wstrb_r <= '0;
		end else if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
			S_AXI_WREADY_O <= 1'b0;
			w_held_r <= 1'b1;
			wdata_r <= S_AXI_WDATA_I;
			wstrb_r <= S_AXI_WSTRB_I;
		end else begin
			if (commit) begin
				w_held_r <= 1'b0;
			end
			S_AXI_WREADY_O <= !w_held_r && !S_AXI_BVALID_O;
		end
	end

	assign commit = aw_held_r && w_held_r && !S_AXI_BVALID_O;
	assign wr_config = commit && awaddr_r == `WDT_CONFIG_ADDR && wstrb_r[0];
	assign wr_status = commit && awaddr_r == `WDT_STATUS_ADDR && wstrb_r[0];
	assign wr_service = commit && awaddr_r == `WDT_SERVICE_ADDR
		&& wstrb_r[0];

	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			S_AXI_BVALID_O <= 1'b0;
			S_AXI_BRESP_O <= `WDT_RESP_OKAY;
		end else if (commit) begin
			S_AXI_BVALID_O <= 1'b1;
			if (awaddr_r == `WDT_CONFIG_ADDR || awaddr_r == `WDT_STATUS_ADDR
				|| awaddr_r == `WDT_SERVICE_ADDR) begin
				S_AXI_BRESP_O <= `WDT_RESP_OKAY;
			end else begin
				S_AXI_BRESP_O <= `WDT_RESP_SLVERR;
			end
		end else if (S_AXI_BREADY_I) begin
			S_AXI_BVALID_O <= 1'b0;
		end
	end

	// Read path: address decoded in the cycle it is taken
	assign ar_take = S_AXI_ARVALID_I && S_AXI_ARREADY_O;

	always_comb begin
		rdata_nxt = '0;
		rresp_nxt = `WDT_RESP_OKAY;
		case (S_AXI_ARADDR_I)
			`WDT_CONFIG_ADDR: begin
				rdata_nxt[`WDT_CFG_RATE_BIT] = cfg_r.timeout_rate_select;
				rdata_nxt[`WDT_CFG_DIS_BIT] = cfg_r.watchdog_disable;
				rdata_nxt[`WDT_CFG_STOPDIS_BIT] = cfg_r.stop_disable;
			end
			`WDT_STATUS_ADDR: begin
				rdata_nxt[`WDT_ST_CAUSE_BIT] = cause_r;
				rdata_nxt[`WDT_ST_RUN_BIT] = !disabled;
				rdata_nxt[`WDT_ST_MON_BIT] = mon_r != MON_OFF;
				rdata_nxt[`WDT_ST_CNT_LSB +: `WDT_CNT_W] = cnt_r;
			end
			`WDT_SERVICE_ADDR: begin
				rdata_nxt[7:0] = RESET_VECTOR_LOW;
			end
			default: begin
				rresp_nxt = `WDT_RESP_SLVERR;
			end
		endcase
	end

	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			S_AXI_ARREADY_O <= 1'b0;
			S_AXI_RVALID_O <= 1'b0;
			S_AXI_RDATA_O <= '0;
			S_AXI_RRESP_O <= `WDT_RESP_OKAY;
		end else if (ar_take) begin
			S_AXI_ARREADY_O <= 1'b0;
			S_AXI_RVALID_O <= 1'b1;
			S_AXI_RDATA_O <= rdata_nxt;
			S_AXI_RRESP_O <= rresp_nxt;
		end else if (S_AXI_RVALID_O) begin
			if (S_AXI_RREADY_I) begin
				S_AXI_RVALID_O <= 1'b0;
			end
		end else begin
			S_AXI_ARREADY_O <= 1'b1;
		end
	end

	// Configuration register
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			cfg_r <= '0;
		end else if (wr_config) begin
			cfg_r.timeout_rate_select <= wdata_r[`WDT_CFG_RATE_BIT];
			cfg_r.watchdog_disable <= wdata_r[`WDT_CFG_DIS_BIT];
			cfg_r.stop_disable <= wdata_r[`WDT_CFG_STOPDIS_BIT];
		end
	end

	// Cause flag: a new watchdog reset beats a write-one clear
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			cause_r <= 1'b0;
		end else if (overflow) begin
			cause_r <= 1'b1;
		end else if (wr_status && wdata_r[`WDT_ST_CAUSE_BIT]) begin
			cause_r <= 1'b0;
		end
	end

	// Monitor mode disable tracking
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			mon_r <= MON_OFF;
		end else begin
			case (mon_r)
				MON_OFF: begin
					if (MON_ENTER_I && tv.irq_pin) begin
						mon_r <= MON_TEST_V;
					end else if (MON_ENTER_I) begin
						mon_r <= MON_BLANK;
					end
				end
				MON_TEST_V: begin
					if (!tv.irq_pin && !tv.rst_pin) begin
						mon_r <= MON_OFF;
					end
				end
				MON_BLANK: begin
					mon_r <= MON_BLANK;
				end
				default: begin
					mon_r <= MON_OFF;
				end
			endcase
		end
	end

	assign disabled = cfg_r.watchdog_disable
		|| mon_r != MON_OFF
		|| (BREAK_I && tv.rst_pin);

	// Oscillator tick divider, free running
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			div_r <= '0;
			tick <= 1'b0;
		end else if (div_r == DIV_W'(OSC_DIV - 1)) begin
			div_r <= '0;
			tick <= 1'b1;
		end else begin
			div_r <= div_r + 1'b1;
			tick <= 1'b0;
		end
	end

	// Power-on prescaler clear after 4096 ticks
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			por_cnt_r <= '0;
			por_done_r <= 1'b0;
		end else if (tick && !por_done_r) begin
			if (por_cnt_r == 13'(`WDT_POR_TICKS - 1)) begin
				por_done_r <= 1'b1;
			end
			por_cnt_r <= por_cnt_r + 1'b1;
		end
	end

	assign por_clr = tick && !por_done_r
		&& por_cnt_r == 13'(`WDT_POR_TICKS - 1);

	// Wait mode is deliberately not an input: counting goes on
	assign stop_gate = STOP_MODE_I;
	assign clear_all = INT_RESET_I || SYS_RESET_O || disabled;
	assign clear_pre = stop_gate || (STOP_EXEC_I && !cfg_r.stop_disable)
		|| VECTOR_FETCH_I
		|| por_clr;

	assign elapsed = {cnt_r, pre_r};
	assign period = cfg_r.timeout_rate_select ? `WDT_PERIOD_SHORT
		: `WDT_PERIOD_LONG;
	assign overflow = tick && !stop_gate && !clear_all && !clear_pre
		&& !wr_service && elapsed == period - 1'b1;

	// Prescaler and counter
	always_ff @(posedge CLK_I) begin
		if (RESET_I || clear_all || overflow) begin
			pre_r <= '0;
			cnt_r <= '0;
		end else if (wr_service) begin
			cnt_r <= '0;
			pre_r[11:4] <= '0;
		end else if (clear_pre) begin
			pre_r <= '0;
		end else if (tick) begin
			pre_r <= pre_r + 1'b1;
			if (&pre_r) begin
				cnt_r <= cnt_r + 1'b1;
			end
		end
	end

	// Reset pin pulse of 32 ticks, also the system reset request
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			pulse_r <= '0;
		end else if (overflow) begin
			pulse_r <= 6'(`WDT_PULSE_TICKS);
		end else if (tick && pulse_r != '0) begin
			pulse_r <= pulse_r - 1'b1;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			RST_PIN_OE_O <= 1'b0;
			SYS_RESET_O <= 1'b0;
			RST_PIN_O <= 1'b0;
		end else begin
			RST_PIN_O <= 1'b0;
			RST_PIN_OE_O <= overflow
				|| !(pulse_r == 6'd1 && tick) && pulse_r != '0;
			SYS_RESET_O <= overflow
				|| !(pulse_r == 6'd1 && tick) && pulse_r != '0;
		end
	end

	// No interrupt output exists; the only action is a reset
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			ILLEGAL_RESET_O <= 1'b0;
		end else begin
			ILLEGAL_RESET_O <= STOP_EXEC_I && cfg_r.stop_disable;
		end
	end
endmodule

// File: operating_watchdog_timer_asserts.sv
// Port assertions for the operating watchdog.
// Assumes binding into operating_watchdog_timer.
`timescale 1ns/100ps
module watchdog_asserts #(
	parameter int OSC_DIV = 2
) (
	input wire logic CLK_I,
	input wire logic RESET_I,
	input wire logic S_AXI_AWVALID_I,
	input wire logic S_AXI_AWREADY_O,
	input wire logic S_AXI_WVALID_I,
	input wire logic S_AXI_WREADY_O,
	input wire logic S_AXI_BVALID_O,
	input wire logic S_AXI_BREADY_I,
	input wire logic S_AXI_ARVALID_I,
	input wire logic S_AXI_ARREADY_O,
	input wire logic S_AXI_RVALID_O,
	input wire logic STOP_EXEC_I,
	input wire logic ILLEGAL_RESET_O,
	input wire logic RST_PIN_O,
	input wire logic RST_PIN_OE_O,
	input wire logic SYS_RESET_O
);
	localparam int PULSE = 32 * OSC_DIV;
	logic [15:0] hi_cnt_r;
	// Length of the current reset pin pulse
	always_ff @(posedge CLK_I) begin
		if (RESET_I || !RST_PIN_OE_O)
			hi_cnt_r <= 16'h0000;
		else
			hi_cnt_r <= hi_cnt_r + 16'h0001;
	end
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RESET_I);
	sequence aw_w_taken;
		S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O;
	endsequence
	sequence pin_low_held;
		RST_PIN_OE_O [*8];
	endsequence
	AST_B_AFTER_AW_W: assert property (aw_w_taken |-> ##2 S_AXI_BVALID_O)
		else $error("write response late");
	AST_B_HOLD: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O)
		else $error("write response dropped");
	AST_R_AFTER_AR: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
		else $error("read data late");
	AST_PIN_ZERO: assert property (RST_PIN_O == 1'b0)
		else $error("reset pin driven high");
	AST_OE_SYS: assert property (RST_PIN_OE_O == SYS_RESET_O)
		else $error("pin drive and system reset differ");
	AST_PULSE_LEN: assert property ($fell(RST_PIN_OE_O) |-> hi_cnt_r == 16'(PULSE))
		else $error("reset pulse length wrong");
	AST_PULSE_MIN: assert property ($rose(RST_PIN_OE_O) |-> pin_low_held)
		else $error("reset pulse too short");
	AST_ILLEGAL_CAUSE: assert property (ILLEGAL_RESET_O |-> $past(STOP_EXEC_I))
		else $error("illegal reset without stop");
	AST_ILLEGAL_ONE: assert property (ILLEGAL_RESET_O |=> !ILLEGAL_RESET_O)
		else $error("illegal reset longer than one cycle");
endmodule
bind operating_watchdog_timer watchdog_asserts #(.OSC_DIV(OSC_DIV)) u_chk (
	.CLK_I(CLK_I), .RESET_I(RESET_I),
	.S_AXI_AWVALID_I(S_AXI_AWVALID_I), .S_AXI_AWREADY_O(S_AXI_AWREADY_O),
	.S_AXI_WVALID_I(S_AXI_WVALID_I), .S_AXI_WREADY_O(S_AXI_WREADY_O),
	.S_AXI_BVALID_O(S_AXI_BVALID_O), .S_AXI_BREADY_I(S_AXI_BREADY_I),
	.S_AXI_ARVALID_I(S_AXI_ARVALID_I), .S_AXI_ARREADY_O(S_AXI_ARREADY_O),
	.S_AXI_RVALID_O(S_AXI_RVALID_O), .STOP_EXEC_I(STOP_EXEC_I),
	.ILLEGAL_RESET_O(ILLEGAL_RESET_O), .RST_PIN_O(RST_PIN_O),
	.RST_PIN_OE_O(RST_PIN_OE_O), .SYS_RESET_O(SYS_RESET_O)
);

// File: tb_operating_watchdog_timer.sv
// Self-checking bench for the operating watchdog.
// Assumes a shortened oscillator divider of 2 clocks per tick.
`timescale 1ns/100ps
`include "watchdog_consts.svh"
module tb_operating_watchdog_timer
	import watchdog_pkg::*;
;
	localparam int D = 2;
	localparam logic [17:0] CFG = `WDT_CONFIG_ADDR;
	localparam logic [17:0] ST = `WDT_STATUS_ADDR;
	localparam logic [17:0] SVC = `WDT_SERVICE_ADDR;
	logic clk = 0, rst = 1, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
	logic irst = 0, sexe = 0, mon = 0, brk = 0, tvi = 0, tvr = 0;
	logic vf = 0, smode = 0;
	logic [17:0] awa = 0, ara = 0;
	logic [31:0] wd = 0;
	wire awr, wrdy, bv, arr, rv, pin, oe, sys, ill;
	wire [1:0] bres, rres;
	wire [31:0] rdat;
	int err_total = 0, comparisons = 0;
	operating_watchdog_timer #(.OSC_DIV(D), .RESET_VECTOR_LOW(8'h5a))
	u_operating_watchdog_timer (.CLK_I(clk), .RESET_I(rst),
		.S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr),
		.S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wv),
		.S_AXI_WREADY_O(wrdy), .S_AXI_BRESP_O(bres), .S_AXI_BVALID_O(bv),
		.S_AXI_BREADY_I(br), .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv),
		.S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdat), .S_AXI_RRESP_O(rres),
		.S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rr), .INT_RESET_I(irst),
		.STOP_EXEC_I(sexe), .STOP_MODE_I(smode), .VECTOR_FETCH_I(vf),
		.MON_ENTER_I(mon), .BREAK_I(brk), .IRQ_TEST_V_I(tvi),
		.RST_TEST_V_I(tvr), .RST_PIN_O(pin), .RST_PIN_OE_O(oe),
		.SYS_RESET_O(sys), .ILLEGAL_RESET_O(ill));
	initial begin
		forever #12.5 clk = ~clk;
	end
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, g);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic hang(input string nm);
		err_total++;
		$display("MISMATCH %s expected handshake seen timeout", nm);
		end_of_test();
	endtask
	task automatic rst_dut;
		rst <= 1;
		repeat (5) @(posedge clk);
		rst <= 0;
		repeat (2) @(posedge clk);
	endtask
	task automatic wr(input logic [17:0] a, input logic [31:0] d, input logic [1:0] e);
		int n;
		n = 0;
		@(posedge clk);
		awa <= a;
		wd <= d;
		awv <= 1;
		wv <= 1;
		br <= 1;
		do begin
			@(posedge clk);
			if (awr) awv <= 0;
			if (wrdy) wv <= 0;
			n++;
		end while (!bv && n < 40);
		if (n >= 40) hang("bvalid");
		br <= 0;
		chk("bresp", 32'(e), 32'(bres));
	endtask
	task automatic rd(input logic [17:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge clk);
		ara <= a;
		arv <= 1;
		rr <= 1;
		do begin
			@(posedge clk);
			if (arr) arv <= 0;
			n++;
		end while (!rv && n < 40);
		if (n >= 40) hang("rvalid");
		rr <= 0;
		d = rdat;
		r = rres;
	endtask
	task automatic rchk(input logic [17:0] a, input logic [31:0] m, e, input string nm);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk("rresp", 32'h0, 32'(r));
		chk(nm, e, d & m);
	endtask
	task automatic quiet(input int c, output logic seen);
		seen = 0;
		repeat (c) begin
			@(posedge clk);
			if (oe !== 1'b0) seen = 1;
		end
	endtask
	task automatic t_stop;
		for (int k = 0; k < 2; k++) begin
			wr(CFG, k ? 32'h5 : 32'h1, 2'h0);
			sexe <= 1;
			@(posedge clk);
			sexe <= 0;
			@(posedge clk);
			chk("illegal reset", 32'(k), 32'(ill));
		end
	endtask
	task automatic t_mon;
		wr(CFG, 32'h1, 2'h0);
		brk <= 1;
		tvr <= 1;
		repeat (4) @(posedge clk);
		rchk(ST, 32'h6, 32'h0, "break disable");
		brk <= 0;
		tvr <= 0;
		tvi <= 1;
		repeat (4) @(posedge clk);
		rchk(ST, 32'h6, 32'h2, "running");
		mon <= 1;
		@(posedge clk);
		mon <= 0;
		tvi <= 0;
		tvr <= 1;
		repeat (4) @(posedge clk);
		rchk(ST, 32'h6, 32'h4, "monitor test v");
		tvr <= 0;
		repeat (4) @(posedge clk);
		rchk(ST, 32'h6, 32'h2, "monitor released");
		mon <= 1;
		@(posedge clk);
		mon <= 0;
		repeat (4) @(posedge clk);
		rchk(ST, 32'h6, 32'h4, "monitor blank");
		rst_dut();
		rchk(ST, 32'h6, 32'h2, "after power on");
	endtask
	task automatic t_timeout(input bit by_int);
		int n, w;
		n = 0;
		w = 0;
		wr(CFG, 32'h1, 2'h0);
		if (by_int) begin
			irst <= 1;
			@(posedge clk);
			irst <= 0;
		end else begin
			// Let the power-on prescaler clear pass before timing
			repeat (4100 * D) @(posedge clk);
			wr(SVC, 32'h0, 2'h0);
		end
		while (!oe && n < 8300 * D) begin
			@(posedge clk);
			n++;
		end
		if (n >= 8300 * D) hang("overflow");
		while (oe && w < 40 * D) begin
			w++;
			@(posedge clk);
		end
		chk("timeout window", 1, 32'(n >= 8160 * D - 4 && n <= 8176 * D + 4));
		chk("pulse width", 32 * D, w);
		rchk(ST, 32'h1, 32'h1, "cause flag");
		wr(ST, 32'h1, 2'h0);
		rchk(ST, 32'h1, 32'h0, "cause cleared");
	endtask
	// Counter holds 1 here; only a prescaler clear keeps off an overflow
	task automatic t_clear;
		logic seen;
		vf <= 1;
		@(posedge clk);
		vf <= 0;
		quiet(2500 * D, seen);
		chk("fetch clear", 0, 32'(seen));
		smode <= 1;
		quiet(2000 * D, seen);
		chk("stop hold", 0, 32'(seen));
		smode <= 0;
		quiet(2500 * D, seen);
		chk("stop gate", 0, 32'(seen));
	endtask
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		logic seen;
		rst_dut();
		rchk(CFG, 32'h7, 32'h0, "config reset");
		rchk(SVC, 32'hffffffff, 32'h5a, "service read");
		rd(18'h00100, d, r);
		chk("unmapped rresp", 32'h2, 32'(r));
		wr(18'h00100, 32'h1, 2'h2);
		t_stop();
		t_mon();
		t_timeout(0);
		t_timeout(1);
		wr(CFG, 32'h1, 2'h0);
		for (int k = 0; k < 2; k++) begin
			wr(SVC, 32'h0, 2'h0);
			quiet(6000 * D, seen);
			chk("serviced", 0, 32'(seen));
		end
		t_clear();
		wr(CFG, 32'h3, 2'h0);
		quiet(8300 * D, seen);
		chk("disabled", 0, 32'(seen));
		rchk(ST, 32'h2, 32'h0, "not running");
		end_of_test();
	end
endmodule
